/* pkg/crm_params.svh */
/*
 * Register offsets, writable-bit masks, reset values and store geometry
 * for the charger register map.
 * Assumes inclusion by bare name from the design files of this block.
 */
`ifndef CRM_PARAMS_SVH
`define CRM_PARAMS_SVH

// Register byte offsets.
`define CRM_OFS_CHIP_IDENTITY       8'h00
`define CRM_OFS_SILICON_REVISION    8'h01
`define CRM_OFS_DEVICE_STATUS_ONE   8'h02
`define CRM_OFS_CHARGE_TIMER_CTRL   8'h1f
`define CRM_OFS_WEAK_BATTERY_CTRL   8'h20
`define CRM_OFS_INPUT_LIMIT_CTRL    8'h21
`define CRM_OFS_INPUT_LIMIT_RDBK    8'h22
`define CRM_OFS_CONVERTER_CFG_ONE   8'h23
`define CRM_OFS_CONVERTER_CFG_TWO   8'h24
`define CRM_OFS_CHARGER_DETECT_CTRL 8'h25
`define CRM_OFS_RESERVED_HOLE_26    8'h26
`define CRM_OFS_CABLE_DETECT_ONE    8'h27
`define CRM_OFS_CABLE_DETECT_TWO    8'h28
`define CRM_OFS_CABLE_DETECT_THREE  8'h29
`define CRM_OFS_INPUT_LIMIT_VALUE   8'h2a
`define CRM_OFS_INPUT_LIMIT_GATING  8'h2b
`define CRM_OFS_ADAPTIVE_CFG_ONE    8'h2c
`define CRM_OFS_ADAPTIVE_CFG_TWO    8'h2d
`define CRM_OFS_ADAPTIVE_CFG_THREE  8'h2e
`define CRM_OFS_DATA_LINE_SWITCH    8'h2f
`define CRM_OFS_MISC_CONTROL        8'h30
`define CRM_OFS_RESERVED_HOLE_31    8'h31
`define CRM_OFS_RESERVED_HOLE_32    8'h32
`define CRM_OFS_LOW_POWER_CONTROL   8'h33
`define CRM_OFS_RESERVED_HOLE_34    8'h34
`define CRM_OFS_FAULT_OUTPUT_SELECT 8'h35

// Writable bits of each stored register.
`define CRM_WMASK_CHARGE_TIMER_CTRL   8'h7f
`define CRM_WMASK_WEAK_BATTERY_CTRL   8'h04
`define CRM_WMASK_INPUT_LIMIT_CTRL    8'hff
`define CRM_WMASK_CONVERTER_CFG_ONE   8'hf0
`define CRM_WMASK_CONVERTER_CFG_TWO   8'h1f
`define CRM_WMASK_CHARGER_DETECT_CTRL 8'hdf
`define CRM_WMASK_CABLE_DETECT_ONE    8'h1f
`define CRM_WMASK_CABLE_DETECT_TWO    8'hff
`define CRM_WMASK_CABLE_DETECT_THREE  8'h0f
`define CRM_WMASK_INPUT_LIMIT_GATING  8'h1f
`define CRM_WMASK_ADAPTIVE_CFG_ONE    8'h81
`define CRM_WMASK_ADAPTIVE_CFG_TWO    8'hff
`define CRM_WMASK_DATA_LINE_SWITCH    8'h03
`define CRM_WMASK_MISC_CONTROL        8'h01
`define CRM_WMASK_LOW_POWER_CONTROL   8'h81
`define CRM_WMASK_FAULT_OUTPUT_SELECT 8'hc0

// Reset value of every stored control byte.
`define CRM_CTRL_RESET 8'h00

// The stored window of the map and its size in bytes.
`define CRM_STORE_FIRST 8'h1f
`define CRM_STORE_LAST  8'h35
`define CRM_STORE_DEPTH 23

`endif

/* pkg/crm_pkg.sv */
/*
 * Types of the charger register map: status byte, read-only field
 * inputs and the serial slave states.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package crm_pkg;

    // Device status one, bit 7 down to bit 0.
    typedef struct packed {
        logic system_fault_flag;
        logic input_overvoltage_flag;
        logic input_current_limiting_flag;
        logic system_regulation;
        logic thermal_shutdown;
        logic thermal_warning;
        logic battery_present;
        logic weak_battery_timer_running;
    } crm_status_s;

    // Read-only fields supplied by the charger core.
    typedef struct packed {
        logic [7:0] limit_readback;
        logic [6:0] limit_value;
        logic [4:0] adaptive_timing;
        logic [2:0] weak_battery_stage;
    } crm_ro_s;

    // Serial slave states, Gray coded along the usual path.
    typedef enum logic [3:0] {
        CRM_IDLE      = 4'h0,
        CRM_ADDR      = 4'h1,
        CRM_ADDR_ACK  = 4'h3,
        CRM_REG       = 4'h2,
        CRM_REG_ACK   = 4'h6,
        CRM_WDATA     = 4'h7,
        CRM_WDATA_ACK = 4'h5,
        CRM_RDATA     = 4'h4,
        CRM_RDATA_ACK = 4'hc
    } crm_state_e;

endpackage

/* src/crm_byte_store.sv */
/*
 * Byte store for the writable control registers, with a registered
 * read port and every word also presented in parallel.
 * Assumes one writer and a read address held stable for a cycle.
 */
`timescale 1ns/10ps
`include "crm_params.svh"

module crm_byte_store #(
    parameter int         WIDTH       = 8,
    parameter int         DEPTH       = `CRM_STORE_DEPTH,
    parameter int         AW          = 5,
    parameter logic [7:0] RESET_VALUE = `CRM_CTRL_RESET
) (
    // Clock and reset.
    input  wire logic                   i_core_clk,
    input  wire logic                   i_reset,
    // Write port.
    input  wire logic                   i_we,
    input  wire logic [AW-1:0]          i_waddr,
    input  wire logic [WIDTH-1:0]       i_wdata,
    // Read port.
    input  wire logic [AW-1:0]          i_raddr,
    output logic      [WIDTH-1:0]       o_rdata,
    // All words side by side.
    output logic      [DEPTH*WIDTH-1:0] o_flat
);

    logic [WIDTH-1:0] words [DEPTH];

    // Each word loads on its own write select.
    for (genvar g = 0; g < DEPTH; g++) begin : g_word
        always_ff @(posedge i_core_clk) begin
            if (i_reset) begin
                words[g] <= RESET_VALUE[WIDTH-1:0];
            end else if (i_we && (i_waddr == AW'(g))) begin
                words[g] <= i_wdata;
            end
        end
        assign o_flat[g*WIDTH +: WIDTH] = words[g];
    end

    // Read data leaves a register; out-of-range reads give zero.
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_rdata <= '0;
        end else if (int'(i_raddr) < DEPTH) begin
            o_rdata <= words[i_raddr];
        end else begin
            o_rdata <= '0;
        end
    end

endmodule

/* src/crm_register_map.sv */
/*
 * Register map of the charger: serial two-wire slave, identity and
 * revision bytes, device status one and the upper control registers.
 * Assumes SCL and SDA are synchronous to i_core_clk and that each SCL
 * phase lasts at least two core clock cycles.
 */
`timescale 1ns/10ps
`include "crm_params.svh"

module crm_register_map #(
    parameter logic [6:0] SLAVE_ADDR = 7'h2a,
    parameter logic [7:0] CHIP_ID    = 8'h5a, // Arbitrary value.
    parameter logic [3:0] REV_UPPER  = 4'h1,  // Arbitrary value.
    parameter logic [3:0] REV_LOWER  = 4'h2,  // Arbitrary value.
    parameter int         DEPTH      = `CRM_STORE_DEPTH
) (
    // Clock and reset.
    input  wire logic                  i_core_clk,
    input  wire logic                  i_reset,
    // Two-wire serial bus, open drain data.
    input  wire logic                  i_scl,
    input  wire logic                  i_sda,
    output logic                       o_sda,
    output logic                       o_sda_oe_n,
    // Charger core state.
    input  wire logic                  i_write_lock_setting,
    input  wire crm_pkg::crm_status_s  i_status,
    input  wire crm_pkg::crm_ro_s      i_readonly,
    // Control bytes and latched fault.
    output logic      [DEPTH*8-1:0]    o_control,
    output logic                       o_system_fault_flag
);

    localparam int AW = $clog2(DEPTH);

    crm_pkg::crm_state_e  state;
    crm_pkg::crm_status_s status_one;
    logic       scl_q;
    logic       sda_q;
    logic [2:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] tx;
    logic [7:0] pointer;
    logic [7:0] rel_index;
    logic [7:0] rd_byte;
    logic [7:0] in_byte;
    logic [7:0] store_rdata;
    logic       is_read;
    logic       ack_half;
    logic       sda_drive;
    logic       scl_rise;
    logic       scl_fall;
    logic       bus_start;
    logic       bus_stop;
    logic       wr_fire;
    logic       rd_done;
    logic       store_we;
    logic       clear_when_read;

    // True for offsets held in the byte store.
    function automatic logic in_store(input logic [7:0] addr);
        return (addr >= `CRM_STORE_FIRST) && (addr <= `CRM_STORE_LAST);
    endfunction

    // Writable bits of a stored offset; zero for read-only or holes.
    function automatic logic [7:0] wr_mask(input logic [7:0] addr);
        case (addr)
            `CRM_OFS_CHARGE_TIMER_CTRL:   return `CRM_WMASK_CHARGE_TIMER_CTRL;
            `CRM_OFS_WEAK_BATTERY_CTRL:   return `CRM_WMASK_WEAK_BATTERY_CTRL;
            `CRM_OFS_INPUT_LIMIT_CTRL:    return `CRM_WMASK_INPUT_LIMIT_CTRL;
            `CRM_OFS_CONVERTER_CFG_ONE:   return `CRM_WMASK_CONVERTER_CFG_ONE;
            `CRM_OFS_CONVERTER_CFG_TWO:   return `CRM_WMASK_CONVERTER_CFG_TWO;
            `CRM_OFS_CHARGER_DETECT_CTRL:
                return `CRM_WMASK_CHARGER_DETECT_CTRL;
            `CRM_OFS_CABLE_DETECT_ONE:    return `CRM_WMASK_CABLE_DETECT_ONE;
            `CRM_OFS_CABLE_DETECT_TWO:    return `CRM_WMASK_CABLE_DETECT_TWO;
            `CRM_OFS_CABLE_DETECT_THREE:  return `CRM_WMASK_CABLE_DETECT_THREE;
            `CRM_OFS_INPUT_LIMIT_GATING:  return `CRM_WMASK_INPUT_LIMIT_GATING;
            `CRM_OFS_ADAPTIVE_CFG_ONE:    return `CRM_WMASK_ADAPTIVE_CFG_ONE;
            `CRM_OFS_ADAPTIVE_CFG_TWO:    return `CRM_WMASK_ADAPTIVE_CFG_TWO;
            `CRM_OFS_DATA_LINE_SWITCH:    return `CRM_WMASK_DATA_LINE_SWITCH;
            `CRM_OFS_MISC_CONTROL:        return `CRM_WMASK_MISC_CONTROL;
            `CRM_OFS_LOW_POWER_CONTROL:   return `CRM_WMASK_LOW_POWER_CONTROL;
            `CRM_OFS_FAULT_OUTPUT_SELECT:
                return `CRM_WMASK_FAULT_OUTPUT_SELECT;
            default:                      return 8'h00;
        endcase
    endfunction

    // Offsets that turn read-only while the write lock is set.
    function automatic logic lock_applies(input logic [7:0] addr);
        return (addr == `CRM_OFS_CHARGE_TIMER_CTRL) ||
               (addr == `CRM_OFS_WEAK_BATTERY_CTRL);
    endfunction

    // Bus line history for edge, start and stop detection.
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= i_scl;
            sda_q <= i_sda;
        end
    end

    // Bus events and the byte being completed on this rising edge.
    assign scl_rise  = i_scl & ~scl_q;
    assign scl_fall  = ~i_scl & scl_q;
    assign bus_start = i_scl & scl_q & sda_q & ~i_sda;
    assign bus_stop  = i_scl & scl_q & ~sda_q & i_sda;
    assign in_byte   = {shift[6:0], i_sda};
    assign wr_fire   = (state == crm_pkg::CRM_WDATA) & scl_rise &
                       (bit_cnt == 3'h7);
    assign rd_done   = (state == crm_pkg::CRM_RDATA) & scl_fall &
                       (bit_cnt == 3'h7);

    // Writes keep only writable bits and skip locked registers.
    assign store_we = wr_fire & in_store(pointer) &
                      (wr_mask(pointer) != 8'h00) &
                      ~(i_write_lock_setting & lock_applies(pointer));
    assign rel_index = pointer - `CRM_STORE_FIRST;

    // A completed read of status one clears the latched fault.
    assign clear_when_read = rd_done &
                             (pointer == `CRM_OFS_DEVICE_STATUS_ONE);

    // Serial slave sequencing, pointer and data line drive.
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            state     <= crm_pkg::CRM_IDLE;
            bit_cnt   <= 3'h0;
            shift     <= 8'h00;
            tx        <= 8'h00;
            pointer   <= 8'h00;
            is_read   <= 1'b0;
            ack_half  <= 1'b0;
            sda_drive <= 1'b0;
        end else if (bus_stop) begin
            state     <= crm_pkg::CRM_IDLE;
            ack_half  <= 1'b0;
            sda_drive <= 1'b0;
        end else if (bus_start) begin
            state     <= crm_pkg::CRM_ADDR;
            bit_cnt   <= 3'h0;
            ack_half  <= 1'b0;
            sda_drive <= 1'b0;
        end else begin
            case (state)
                crm_pkg::CRM_ADDR, crm_pkg::CRM_REG,
                crm_pkg::CRM_WDATA: begin
                    if (scl_rise) begin
                        shift   <= in_byte;
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == 3'h7) begin
                            if (state == crm_pkg::CRM_ADDR) begin
                                is_read <= i_sda;
                                state   <= (shift[6:0] == SLAVE_ADDR) ?
                                           crm_pkg::CRM_ADDR_ACK :
                                           crm_pkg::CRM_IDLE;
                            end else if (state == crm_pkg::CRM_REG) begin
                                pointer <= in_byte;
                                state   <= crm_pkg::CRM_REG_ACK;
                            end else begin
                                pointer <= pointer + 8'h01;
                                state   <= crm_pkg::CRM_WDATA_ACK;
                            end
                        end
                    end
                end
                crm_pkg::CRM_ADDR_ACK, crm_pkg::CRM_REG_ACK,
                crm_pkg::CRM_WDATA_ACK: begin
                    if (scl_fall && !ack_half) begin
                        ack_half  <= 1'b1;
                        sda_drive <= 1'b1;
                    end else if (scl_fall) begin
                        ack_half  <= 1'b0;
                        sda_drive <= 1'b0;
                        if (state == crm_pkg::CRM_ADDR_ACK && is_read) begin
                            tx        <= rd_byte;
                            sda_drive <= ~rd_byte[7];
                            state     <= crm_pkg::CRM_RDATA;
                        end else if (state == crm_pkg::CRM_ADDR_ACK) begin
                            state <= crm_pkg::CRM_REG;
                        end else begin
                            state <= crm_pkg::CRM_WDATA;
                        end
                    end
                end
                crm_pkg::CRM_RDATA: begin
                    if (scl_fall) begin
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == 3'h7) begin
                            sda_drive <= 1'b0;
                            pointer   <= pointer + 8'h01;
                            state     <= crm_pkg::CRM_RDATA_ACK;
                        end else begin
                            tx        <= {tx[6:0], 1'b0};
                            sda_drive <= ~tx[6];
                        end
                    end
                end
                crm_pkg::CRM_RDATA_ACK: begin
                    if (scl_rise && i_sda) begin
                        state <= crm_pkg::CRM_IDLE;
                    end else if (scl_rise) begin
                        ack_half <= 1'b1;
                    end else if (scl_fall && ack_half) begin
                        ack_half  <= 1'b0;
                        tx        <= rd_byte;
                        sda_drive <= ~rd_byte[7];
                        state     <= crm_pkg::CRM_RDATA;
                    end
                end
                crm_pkg::CRM_IDLE: begin
                    ack_half <= 1'b0;
                end
                default: begin
                    state     <= crm_pkg::CRM_IDLE;
                    sda_drive <= 1'b0;
                end
            endcase
        end
    end

    // Status one: live flags follow the core, system fault latches.
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            status_one <= '0;
        end else begin
            status_one.input_overvoltage_flag <=
                i_status.input_overvoltage_flag;
            status_one.input_current_limiting_flag <=
                i_status.input_current_limiting_flag;
            status_one.weak_battery_timer_running <=
                i_status.weak_battery_timer_running;
            status_one.system_regulation <= i_status.system_regulation;
            status_one.thermal_shutdown  <= i_status.thermal_shutdown;
            status_one.thermal_warning   <= i_status.thermal_warning;
            status_one.battery_present   <= i_status.battery_present;
            // A new undervoltage wins over a clear in the same cycle.
            if (i_status.system_fault_flag) begin
                status_one.system_fault_flag <= 1'b1;
            end else if (clear_when_read) begin
                status_one.system_fault_flag <= 1'b0;
            end
        end
    end

    // Byte presented for the next read at the current pointer.
    always_comb begin
        rd_byte = 8'h00;
        case (pointer)
            `CRM_OFS_CHIP_IDENTITY:     rd_byte = CHIP_ID;
            `CRM_OFS_SILICON_REVISION:  rd_byte = {REV_UPPER, REV_LOWER};
            `CRM_OFS_DEVICE_STATUS_ONE: rd_byte = status_one;
            `CRM_OFS_INPUT_LIMIT_RDBK:  rd_byte = i_readonly.limit_readback;
            `CRM_OFS_INPUT_LIMIT_VALUE:
                rd_byte = {1'b0, i_readonly.limit_value};
            `CRM_OFS_ADAPTIVE_CFG_THREE:
                rd_byte = {3'h0, i_readonly.adaptive_timing};
            `CRM_OFS_WEAK_BATTERY_CTRL:
                rd_byte = {i_readonly.weak_battery_stage, 5'h00} |
                          (store_rdata & wr_mask(pointer));
            default: begin
                if (in_store(pointer)) begin
                    rd_byte = store_rdata & wr_mask(pointer);
                end
            end
        endcase
    end

    // Writable control bytes.
    crm_byte_store #(
        .WIDTH       (8),
        .DEPTH       (DEPTH),
        .AW          (AW),
        .RESET_VALUE (`CRM_CTRL_RESET)
    ) u_store (
        .i_core_clk (i_core_clk),
        .i_reset    (i_reset),
        .i_we       (store_we),
        .i_waddr    (rel_index[AW-1:0]),
        .i_wdata    (in_byte & wr_mask(pointer)),
        .i_raddr    (rel_index[AW-1:0]),
        .o_rdata    (store_rdata),
        .o_flat     (o_control)
    );

    // Open drain data line: only ever pulls low.
    assign o_sda               = 1'b0;
    assign o_sda_oe_n          = ~sda_drive;
    assign o_system_fault_flag = status_one.system_fault_flag;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_reset);

    sequence s_locked_write;
        wr_fire && i_write_lock_setting && lock_applies(pointer);
    endsequence

    sequence s_fault_cleared;
        clear_when_read && !i_status.system_fault_flag;
    endsequence

    a_lock_no_store: assert property (s_locked_write |-> !store_we)
        else $error("Locked register accepted a write.");
    a_lock_stable: assert property (s_locked_write |=> $stable(o_control))
        else $error("Locked register content changed.");
    a_fault_sets: assert property (i_status.system_fault_flag
        |=> status_one.system_fault_flag)
        else $error("System fault did not set on undervoltage.");
    a_fault_holds: assert property (status_one.system_fault_flag
        && !clear_when_read |=> status_one.system_fault_flag)
        else $error("System fault dropped without a read.");
    a_fault_clears: assert property (s_fault_cleared
        |=> !status_one.system_fault_flag)
        else $error("System fault not cleared by its read.");
    a_ovp_follows: assert property (!$past(i_reset) |->
        status_one.input_overvoltage_flag
        == $past(i_status.input_overvoltage_flag))
        else $error("Overvoltage flag does not follow the core.");
    a_input_current_limiting_flag_follows: assert property (!$past(i_reset) |->
        status_one.input_current_limiting_flag
        == $past(i_status.input_current_limiting_flag))
        else $error("Current limiting flag does not follow the core.");
    a_weak_timer: assert property (!$past(i_reset) |->
        status_one.weak_battery_timer_running
        == $past(i_status.weak_battery_timer_running))
        else $error("Weak battery bit does not follow its timer.");
    a_rev_nibbles: assert property (pointer == `CRM_OFS_SILICON_REVISION
        |-> rd_byte[7:4] == REV_UPPER && rd_byte[3:0] == REV_LOWER)
        else $error("Revision byte does not hold both nibbles.");
    a_hole_zero: assert property ((pointer == `CRM_OFS_RESERVED_HOLE_26
        || pointer > `CRM_STORE_LAST) |-> rd_byte == 8'h00)
        else $error("Unimplemented offset read non-zero.");

endmodule

/* verif/crm_host_model.sv */
/*
 * Two-wire bus host model with bit, byte and register tasks.
 * Assumes SDA has a pull-up and its wire level comes in on i_sda_wire.
 */
`timescale 1ns/10ps
module crm_host_model (
    // Clock and wire level.
    input  wire logic i_core_clk,
    input  wire logic i_sda_wire,
    // Bus drive; a low enable pulls SDA down.
    output logic      o_scl,
    output logic      o_sda_oe_n
);
    logic nak = 1'b0; // Set by any missing acknowledge.
    // The bus is idle and released at time zero.
    initial begin
        o_scl      = 1'b1;
        o_sda_oe_n = 1'b1;
    end
    // Sets both lines after an edge and holds them for three cycles.
    task automatic step(input logic c, input logic o);
        o_scl      <= c;
        o_sda_oe_n <= o;
        repeat (3) @(posedge i_core_clk);
    endtask
    // One clock pulse: data set while low, wire sampled late in high.
    task automatic pulse(input logic b, output logic r);
        step(1'b0, b);
        step(1'b1, b);
        r = i_sda_wire;
        step(1'b0, b);
    endtask
    // Start, also a repeated start, and stop.
    task automatic start();
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
    endtask
    task automatic stop();
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask
    // Sends a byte MSB first and notes a missing acknowledge.
    task automatic send(input logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            pulse(d[i], r);
        end
        pulse(1'b1, r);
        if (r !== 1'b0) nak = 1'b1;
    endtask
    // Register write of one or two bytes, the first byte in the upper half.
    task automatic wr(input logic [7:0] a, input int n,
                      input logic [15:0] d);
        start();
        send(8'h54);
        send(a);
        if (n == 2) begin
            send(d[15:8]);
        end
        send(d[7:0]);
        stop();
    endtask
    // Register read of one or two bytes; every byte but the last is
    // acknowledged, so a burst exercises the pointer increment.
    task automatic rd(input logic [7:0] a, input int n,
                      output logic [15:0] d);
        logic r;
        d = 16'h0000;
        start();
        send(8'h54);
        send(a);
        start();
        send(8'h55);
        for (int i = 0; i < 8 * n; i++) begin
            pulse(1'b1, r);
            d = {d[14:0], r};
            if (i % 8 == 7) begin
                pulse(i == 8 * n - 1, r);
            end
        end
        stop();
    endtask
endmodule

/* verif/tb_top.sv */
/*
 * Self-checking bench of the charger register map.
 * Assumes the package, design files and host model compile first.
 */
`timescale 1ns/10ps
module tb_top;
    logic                 i_core_clk = 1'b0;
    logic                 i_reset    = 1'b1;
    logic                 lock       = 1'b0;
    crm_pkg::crm_status_s st         = '0;
    crm_pkg::crm_ro_s     ro         = '0;
    logic                 scl, host_oe_n, dev_sda, dev_oe_n, fault, sda_w;
    logic [183:0]         ctrl;
    logic [7:0]           off;
    logic [15:0]          pair;
    logic [7:0]           msk [23] = '{8'h7f, 8'h04, 8'hff, 8'h00, 8'hf0,
        8'h1f, 8'hdf, 8'h00, 8'h1f, 8'hff, 8'h0f, 8'h00, 8'h1f, 8'h81,
        8'hff, 8'h00, 8'h03, 8'h01, 8'h00, 8'h00, 8'h81, 8'h00, 8'hc0};
    int                   num_errors = 0;
    int                   n_compared = 0;
    int                   cyc        = 0;
    // Wired-AND data line with a pull-up, and an 8 ns clock.
    assign sda_w = host_oe_n & (dev_oe_n | dev_sda);
    always #4 i_core_clk = ~i_core_clk;
    crm_host_model i_crm_host_model (.i_core_clk(i_core_clk),
        .i_sda_wire(sda_w), .o_scl(scl), .o_sda_oe_n(host_oe_n));
    // Identity values here are arbitrary.
    crm_register_map #(.SLAVE_ADDR(7'h2a), .CHIP_ID(8'h3c),
        .REV_UPPER(4'h9), .REV_LOWER(4'h6)) i_crm_register_map (
        .i_core_clk(i_core_clk), .i_reset(i_reset), .i_scl(scl),
        .i_sda(sda_w), .o_sda(dev_sda), .o_sda_oe_n(dev_oe_n),
        .i_write_lock_setting(lock), .i_status(st), .i_readonly(ro),
        .o_control(ctrl), .o_system_fault_flag(fault));
    // Byte compare, read-and-compare and write helpers.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        logic [15:0] v;
        i_crm_host_model.rd(a, 1, v);
        chk(v[7:0], exp);
    endtask
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        i_crm_host_model.wr(a, 1, {8'h00, d});
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic end_sim();
        $display("errors=%0d compared=%0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Cycle ceiling against a hung bus.
    always @(posedge i_core_clk) begin
        cyc++;
        if (cyc == 40000) begin
            num_errors++;
            end_sim();
        end
    end
    // Main sequence.
    initial begin
        repeat (16) @(posedge i_core_clk);
        i_reset <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        rdc(8'h00, 8'h3c);
        rdc(8'h01, 8'h96);
        // A two-byte read walks the pointer across both identity bytes.
        i_crm_host_model.rd(8'h00, 2, pair);
        chk(pair[15:8], 8'h3c);
        chk(pair[7:0], 8'h96);
        // Each stored offset takes a write of exactly its writable-bit mask.
        for (int k = 0; k < 23; k++) begin
            off = 8'h1f + 8'(k);
            w(off, msk[k]);
            rdc(off, msk[k]);
            chk(ctrl[8*k +: 8], msk[k]);
        end
        // Locked offsets keep their bytes, others still take writes.
        lock <= 1'b1;
        w(8'h1f, 8'h00);
        w(8'h20, 8'h00);
        w(8'h21, 8'h00);
        rdc(8'h1f, 8'h7f);
        rdc(8'h21, 8'h00);
        lock <= 1'b0;
        w(8'h1f, 8'h00);
        rdc(8'h1f, 8'h00);
        // A two-byte write lands on two consecutive offsets.
        i_crm_host_model.wr(8'h2f, 2, 16'h0200);
        chk(ctrl[8*16 +: 8], 8'h02);
        chk(ctrl[8*17 +: 8], 8'h00);
        // Status flags, the latched fault and read-only fields.
        st <= 8'he1;
        ro <= {8'hc3, 7'h55, 5'h1b, 3'h5};
        rdc(8'h02, 8'he1);
        st <= 8'h00;
        repeat (2) @(posedge i_core_clk);
        chk({7'h0, fault}, 8'h01);
        rdc(8'h02, 8'h80);
        chk({7'h0, fault}, 8'h00);
        rdc(8'h02, 8'h00);
        rdc(8'h20, 8'ha4);
        rdc(8'h22, 8'hc3);
        rdc(8'h2a, 8'h55);
        rdc(8'h2e, 8'h1b);
        rdc(8'h40, 8'h00);
        chk({7'h0, i_crm_host_model.nak}, 8'h00);
        end_sim();
    end
endmodule
